// >>> core/pop_oneshot.sv
// Summary of operation
// - one of two channels; five modes exist, only single-pulse runs here
// - mode is fixed once configuration is locked; later writes ignored
// - go echo shows the go bit as received
// - config selects plain sensed input or hardware gate; default plain
// - gated: with go set, first gate rising edge starts the sequence
// - gate rising edges during a running sequence are ignored
// - gated: each later gate edge with go still set starts again
// - start edge begins on-delay and sets running together
// - after on-delay, pulse for programmed duration, then running clears
// - pulse width fault clears when next sequence starts
// - go falling during delay or pulse aborts, clearing output and running
// - time base 0.1 ms or 1 ms sets resolution; default 0.1 ms
// - pulse duration is time base times 16-bit controller value
// - changed duration during pulse ends pulse at new elapsed target
// - new duration below elapsed time aborts and sets pulse width fault
// - configured on-delay is time base times 16-bit value, default zero
// - short layout delay is factor times 0.1 times configured delay
// - a changed delay factor applies only from the next start
// - bus cycle synchronism has no effect on timing here
// - no pulse when duration is below 2 (fast) or 1 (slow)
// - on-delay under 0.2 ms, or a zero factor in the short layout, is zero; capped at 65535 counts (65.535 s slow, 6.5535 s fast)
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
module pop_oneshot import pop_pkg::*; #(
  parameter int FAST_CYCLES = POP_FAST_CYCLES,
  parameter int SLOW_CYCLES = POP_SLOW_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] address,
  input wire logic [31:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [31:0] readData,
  // process side
  input wire logic senseInput,
  output logic pulseOut,
  // feedback
  output logic sequenceRunning,
  output logic goEcho,
  output logic pulseWidthFault
);
  // control word
  logic softwareGo;
  logic outputOverride;
  logic [7:0] delayFactor;
  // controller values
  logic [15:0] pulseDuration;
  logic [15:0] longDelay;
  // configuration
  pop_mode_type cfgMode;
  logic cfgSlowBase;
  logic inputRoleSelect;
  logic cfgLongLayout;
  logic cfgLocked;
  logic [15:0] cfgDelay;
  // sequencer
  pop_state_type state;
  logic [15:0] delayCount;
  logic [15:0] elapsed;
  logic [15:0] latchedDelay;
  logic [3:0] seqCount;
  // edge detection
  logic goPrev;
  logic gatePrev;
  // derived terms
  logic hardwareGate;
  logic goRise;
  logic gateRise;
  logic modeIsPulse;
  logic startPlain;
  logic startGated;
  logic startNow;
  logic abortNow;
  logic tick;
  logic delayDone;
  logic pulseDone;
  logic durationOk;
  logic overrun;
  logic tickRestart;
  logic [15:0] effDelay;
  logic [15:0] minDuration;
  // one-cycle mark of a finished sequence, aborted or faulted ones excluded
  logic seqDone;

  // time-base tick, free of any bus cycle reference
  // the tick phase is restarted at each phase start, so a time of n counts
  // lasts exactly n base periods rather than n minus a partial period
  pop_tick_gen #(
    .FAST_CYCLES(FAST_CYCLES),
    .SLOW_CYCLES(SLOW_CYCLES)
  ) tickGen (
    .clock(clock),
    .reset_n(reset_n),
    .slowBase(cfgSlowBase),
    .restart(tickRestart),
    .tick(tick)
  );

  // effective on-delay from factor and configured value, or the long layout word
  // purely combinational; its result is only latched at a start
  pop_delay_calc delayCalc (
    .slowBase(cfgSlowBase),
    .longLayout(cfgLongLayout),
    .configDelay(cfgDelay),
    .delayFactor(delayFactor),
    .longDelay(longDelay),
    .effDelay(effDelay)
  );

  // control word: go bit, override bit and delay factor
  // the factor is only sampled at a start, so rewriting it mid-sequence is harmless
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      softwareGo <= 1'b0;
      outputOverride <= 1'b0;
      delayFactor <= 8'h00;
    end else if (writeStrobe && address == POP_ADDR_CTRL) begin
      softwareGo <= writeData[POP_CTRL_GO];
      outputOverride <= writeData[POP_CTRL_OVERRIDE];
      delayFactor <= writeData[POP_CTRL_FACTOR_LO +: 8];
    end
  end

  // duration may change at any time; the sequencer checks it every cycle
  // there is no shadow copy: a new value is the new total, elapsed time is kept
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pulseDuration <= POP_DURATION_RESET;
    end else if (writeStrobe && address == POP_ADDR_DURATION) begin
      pulseDuration <= writeData[15:0];
    end
  end

  // direct on-delay count for the long layout
  // ignored in the short layout, where factor and configured delay are used
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      longDelay <= 16'h0000;
    end else if (writeStrobe && address == POP_ADDR_ONDELAY) begin
      longDelay <= writeData[15:0];
    end
  end

  // configuration; the lock bit seals mode and settings until the next reset
  // an unlocked write mid-sequence changes the base at once; software should
  // lock the word before the first start to keep times predictable
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfgMode <= POP_MODE_RESET;
      cfgSlowBase <= 1'b0;
      inputRoleSelect <= 1'b0;
      cfgLongLayout <= 1'b0;
      cfgLocked <= 1'b0;
      cfgDelay <= POP_CFG_DELAY_RESET;
    end else if (writeStrobe && address == POP_ADDR_CONFIG && !cfgLocked) begin
      cfgMode <= pop_mode_type'(writeData[POP_CFG_MODE_LO +: 3]);
      cfgSlowBase <= writeData[POP_CFG_SLOW_BASE];
      inputRoleSelect <= writeData[POP_CFG_GATE_ROLE];
      cfgLongLayout <= writeData[POP_CFG_LONG_LAYOUT];
      cfgLocked <= writeData[POP_CFG_LOCK];
      cfgDelay <= writeData[POP_CFG_DELAY_LO +: 16];
    end
  end

  // previous values for edge detection
  // both reset low, matching the idle level, so no false edge follows reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      goPrev <= 1'b0;
      gatePrev <= 1'b0;
    end else begin
      goPrev <= softwareGo;
      gatePrev <= hardwareGate;
    end
  end

  // start and stop conditions
  // the gate is masked by the role bit so a plain sensed input never starts anything
  assign hardwareGate = senseInput & inputRoleSelect;
  assign goRise = softwareGo & ~goPrev;
  assign gateRise = hardwareGate & ~gatePrev;
  assign modeIsPulse = (cfgMode == POP_MODE_PULSE);
  // plain input role: the go edge itself starts, override must be low
  assign startPlain = !inputRoleSelect && goRise && !outputOverride;
  // gate role: only a gate edge with go held starts; a go edge alone waits
  assign startGated = inputRoleSelect && softwareGo && gateRise && !outputOverride;
  // starts are only looked at when idle, so gate edges mid-sequence fall away
  assign startNow = modeIsPulse && state == POP_IDLE && (startPlain || startGated);
  assign abortNow = (state != POP_IDLE) && !softwareGo;

  // timing terms
  // comparisons are widened by one bit so a count of 65535 cannot wrap to zero
  assign minDuration = cfgSlowBase ? POP_MIN_DUR_SLOW : POP_MIN_DUR_FAST;
  assign durationOk = (pulseDuration >= minDuration);
  assign delayDone = tick && ({1'b0, delayCount} + 17'h00001 >= {1'b0, latchedDelay});
  // elapsed is compared each cycle so a new duration takes effect at once
  assign pulseDone = (elapsed >= pulseDuration) ||
                     (tick && ({1'b0, elapsed} + 17'h00001 >= {1'b0, pulseDuration}));
  assign overrun = (elapsed > pulseDuration);
  assign tickRestart = startNow || (state == POP_DELAY && delayDone);

  // sequencer: idle, on-delay, pulse
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= POP_IDLE;
      pulseOut <= 1'b0;
      sequenceRunning <= 1'b0;
      pulseWidthFault <= 1'b0;
      delayCount <= 16'h0000;
      elapsed <= 16'h0000;
      latchedDelay <= 16'h0000;
    end else begin
      case (state)
        POP_IDLE: begin
          // fault, delay and counters are set up together at the start edge
          if (startNow) begin
            sequenceRunning <= 1'b1;
            pulseWidthFault <= 1'b0;
            latchedDelay <= effDelay;
            delayCount <= 16'h0000;
            elapsed <= 16'h0000;
            if (effDelay == 16'h0000) begin
              state <= POP_PULSE;
              pulseOut <= durationOk;
            end else begin
              state <= POP_DELAY;
            end
          end
        end
        POP_DELAY: begin
          if (abortNow) begin
            state <= POP_IDLE;
            pulseOut <= 1'b0;
            sequenceRunning <= 1'b0;
          end else if (delayDone && !durationOk) begin
            // too short a duration: the sequence ends with no pulse at all
            state <= POP_IDLE;
            pulseOut <= 1'b0;
            sequenceRunning <= 1'b0;
          end else if (delayDone) begin
            state <= POP_PULSE;
            pulseOut <= durationOk;
            elapsed <= 16'h0000;
          end else if (tick) begin
            delayCount <= delayCount + 16'h0001;
          end
        end
        POP_PULSE: begin
          if (abortNow) begin
            state <= POP_IDLE;
            pulseOut <= 1'b0;
            sequenceRunning <= 1'b0;
          end else if (overrun) begin
            state <= POP_IDLE;
            pulseOut <= 1'b0;
            sequenceRunning <= 1'b0;
            pulseWidthFault <= 1'b1;
          end else if (pulseDone || !durationOk) begin
            state <= POP_IDLE;
            pulseOut <= 1'b0;
            sequenceRunning <= 1'b0;
          end else if (tick) begin
            elapsed <= elapsed + 16'h0001;
          end
        end
        default: begin
          state <= POP_IDLE;
          pulseOut <= 1'b0;
          sequenceRunning <= 1'b0;
        end
      endcase
    end
  end

  // a sequence completes at its pulse end, or at the delay end when no pulse is due
  assign seqDone = (state == POP_PULSE && !abortNow && !overrun && (pulseDone || !durationOk)) ||
                   (state == POP_DELAY && !abortNow && delayDone && !durationOk);

  // completed sequences; plain role only toggles 0/1, gate role wraps at 15
  // the counter is never cleared by software, so readers compare differences
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      seqCount <= 4'h0;
    end else if (seqDone) begin
      if (inputRoleSelect) begin
        seqCount <= seqCount + 4'h1;
      end else begin
        seqCount <= {3'b000, ~seqCount[0]};
      end
    end
  end

  // go echo is the received go bit itself
  // it is a plain wire from the go register, so it can never lag the control word
  assign goEcho = softwareGo;

  // read data stands for one cycle after the strobe, zero otherwise
  // returning zero between reads lets a master or together several slaves
  // without a read multiplexer on the far side
  // status bits are the levels of the cycle the strobe is taken in; the sense bit is the unregistered input
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      readData <= 32'h00000000;
    end else begin
      readData <= 32'h00000000;
      if (readStrobe) begin
        case (address)
          POP_ADDR_CTRL: begin
            readData[POP_CTRL_GO] <= softwareGo;
            readData[POP_CTRL_OVERRIDE] <= outputOverride;
            readData[POP_CTRL_FACTOR_LO +: 8] <= delayFactor;
          end
          POP_ADDR_DURATION: begin
            readData[15:0] <= pulseDuration;
          end
          POP_ADDR_ONDELAY: begin
            readData[15:0] <= longDelay;
          end
          POP_ADDR_CONFIG: begin
            readData[POP_CFG_MODE_LO +: 3] <= cfgMode;
            readData[POP_CFG_SLOW_BASE] <= cfgSlowBase;
            readData[POP_CFG_GATE_ROLE] <= inputRoleSelect;
            readData[POP_CFG_LONG_LAYOUT] <= cfgLongLayout;
            readData[POP_CFG_LOCK] <= cfgLocked;
            readData[POP_CFG_DELAY_LO +: 16] <= cfgDelay;
          end
          POP_ADDR_STATUS: begin
            readData[POP_STS_RUNNING] <= sequenceRunning;
            readData[POP_STS_OUTPUT] <= pulseOut;
            readData[POP_STS_SENSE] <= senseInput;
            readData[POP_STS_GO_ECHO] <= softwareGo;
            readData[POP_STS_FAULT] <= pulseWidthFault;
            readData[POP_STS_COUNT_LO +: 4] <= seqCount;
          end
          default: begin
            readData <= 32'h00000000;
          end
        endcase
      end
    end
  end
endmodule // pop_oneshot

// >>> core/pop_pkg.sv
package pop_pkg;
  // clock rate and the two time bases, in their own units
  localparam int POP_CLOCK_MHZ = 100;
  localparam int POP_BASE_FAST_US = 100;
  localparam int POP_BASE_SLOW_US = 1000;
  localparam int POP_FAST_CYCLES = POP_BASE_FAST_US * POP_CLOCK_MHZ;
  localparam int POP_SLOW_CYCLES = POP_BASE_SLOW_US * POP_CLOCK_MHZ;
  localparam int POP_TICK_W = 17;

  // register byte addresses
  localparam logic [7:0] POP_ADDR_CTRL = 8'h00;
  localparam logic [7:0] POP_ADDR_DURATION = 8'h04;
  localparam logic [7:0] POP_ADDR_ONDELAY = 8'h08;
  localparam logic [7:0] POP_ADDR_CONFIG = 8'h0c;
  localparam logic [7:0] POP_ADDR_STATUS = 8'h10;

  // control word fields
  localparam int POP_CTRL_GO = 0;
  localparam int POP_CTRL_OVERRIDE = 1;
  localparam int POP_CTRL_FACTOR_LO = 8;

  // configuration word fields
  localparam int POP_CFG_MODE_LO = 0;
  localparam int POP_CFG_SLOW_BASE = 4;
  localparam int POP_CFG_GATE_ROLE = 5;
  localparam int POP_CFG_LONG_LAYOUT = 6;
  localparam int POP_CFG_LOCK = 7;
  localparam int POP_CFG_DELAY_LO = 16;

  // status word fields
  localparam int POP_STS_RUNNING = 0;
  localparam int POP_STS_OUTPUT = 1;
  localparam int POP_STS_SENSE = 2;
  localparam int POP_STS_GO_ECHO = 3;
  localparam int POP_STS_FAULT = 4;
  localparam int POP_STS_COUNT_LO = 8;

  // operating modes of a channel
  typedef enum logic [2:0] {
    POP_MODE_PULSE = 3'b000,
    POP_MODE_PWM = 3'b001,
    POP_MODE_TRAIN = 3'b010,
    POP_MODE_ONOFF = 3'b011,
    POP_MODE_FREQ = 3'b100
  } pop_mode_type;

  // sequencer states
  typedef enum logic [1:0] {
    POP_IDLE = 2'b00,
    POP_DELAY = 2'b01,
    POP_PULSE = 2'b10
  } pop_state_type;

  // values after reset
  localparam pop_mode_type POP_MODE_RESET = POP_MODE_PWM;
  localparam logic [15:0] POP_DURATION_RESET = 16'h0000;
  localparam logic [15:0] POP_CFG_DELAY_RESET = 16'h0000;

  // limits of times, in time-base counts
  localparam logic [15:0] POP_MIN_DUR_FAST = 16'h0002;
  localparam logic [15:0] POP_MIN_DUR_SLOW = 16'h0001;
  localparam logic [15:0] POP_MIN_DELAY_FAST = 16'h0002;
  localparam logic [23:0] POP_DELAY_MAX = 24'h00ffff;
  localparam logic [23:0] POP_FACTOR_DIV = 24'h00000a;
endpackage

// >>> core/pop_tick_gen.sv
`timescale 1ns/1ps
module pop_tick_gen import pop_pkg::*; #(
  parameter int FAST_CYCLES = POP_FAST_CYCLES,
  parameter int SLOW_CYCLES = POP_SLOW_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // control
  input wire logic slowBase,
  input wire logic restart,
  // one-cycle tick per time-base period
  output logic tick
);
  logic [POP_TICK_W-1:0] count;
  logic [POP_TICK_W-1:0] limit;

  // period end for the selected base
  assign limit = slowBase ? POP_TICK_W'(SLOW_CYCLES - 1) : POP_TICK_W'(FAST_CYCLES - 1);
  assign tick = (count == limit);

  // restart aligns the first tick to a full period after a phase begins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (restart || tick) begin
      count <= '0;
    end else begin
      count <= count + POP_TICK_W'(1);
    end
  end
endmodule // pop_tick_gen

// >>> core/pop_delay_calc.sv
`timescale 1ns/1ps
module pop_delay_calc import pop_pkg::*; (
  // configuration
  input wire logic slowBase,
  input wire logic longLayout,
  input wire logic [15:0] configDelay,
  // controller values
  input wire logic [7:0] delayFactor,
  input wire logic [15:0] longDelay,
  // effective on-delay in time-base counts
  output logic [15:0] effDelay
);
  logic [23:0] product;
  logic [23:0] scaled;
  logic [23:0] raw;
  logic [15:0] clamped;

  // factor carries a weight of one tenth; the divide is costly but sits off the timing loop
  assign product = {16'h0000, delayFactor} * {8'h00, configDelay};
  assign scaled = product / POP_FACTOR_DIV;
  assign raw = longLayout ? {8'h00, longDelay} : scaled;
  assign clamped = (raw > POP_DELAY_MAX) ? POP_DELAY_MAX[15:0] : raw[15:0];
  // below two fast counts the delay is dropped; a zero factor already gives zero
  assign effDelay = (!slowBase && clamped < POP_MIN_DELAY_FAST) ? 16'h0000 : clamped;
endmodule // pop_delay_calc

// >>> testbench/pop_oneshot_assertions.sv
`timescale 1ns/1ps
module pop_oneshot_checker import pop_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] address,
  input wire logic [31:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  input wire logic [31:0] readData,
  // process side and feedback
  input wire logic senseInput,
  input wire logic pulseOut,
  input wire logic sequenceRunning,
  input wire logic goEcho,
  input wire logic pulseWidthFault
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic ctrlWr;
  // control word writes are the only thing allowed to move the go bit
  assign ctrlWr = writeStrobe && address == POP_ADDR_CTRL;
  a_echo_takes_go:
    assert property (ctrlWr |=> goEcho == $past(writeData[POP_CTRL_GO])) else $error("go echo wrong");
  a_echo_holds:
    assert property (!ctrlWr |=> $stable(goEcho)) else $error("go echo moved without write");
  a_abort_clears:
    assert property ($fell(goEcho) |=> !sequenceRunning && !pulseOut) else $error("abort too late");
  a_out_in_run:
    assert property (pulseOut |-> sequenceRunning) else $error("output high while idle");
  a_end_together:
    assert property ($fell(pulseOut) |-> !sequenceRunning) else $error("pulse ended alone");
  a_start_clean:
    assert property ($rose(sequenceRunning) |-> goEcho && !pulseWidthFault) else $error("bad start");
  a_fault_stops:
    assert property ($rose(pulseWidthFault) |-> !sequenceRunning && !pulseOut) else $error("fault kept run");
  a_fault_sticky:
    assert property ($fell(pulseWidthFault) |-> $rose(sequenceRunning)) else $error("fault lost");
  a_status_read:
    assert property (readStrobe && address == POP_ADDR_STATUS |=>
      {readData[4:3], readData[1:0]} == {$past(pulseWidthFault), $past(goEcho),
      $past(pulseOut), $past(sequenceRunning)}) else $error("status word wrong");
  c_pulse: cover property ($rose(pulseOut));
  c_fault: cover property ($rose(pulseWidthFault));
  c_abort: cover property ($fell(goEcho) && sequenceRunning);
endmodule // pop_oneshot_checker

bind pop_oneshot pop_oneshot_checker u_chk (.clock(clock), .reset_n(reset_n), .address(address),
  .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
  .readData(readData), .senseInput(senseInput), .pulseOut(pulseOut),
  .sequenceRunning(sequenceRunning), .goEcho(goEcho), .pulseWidthFault(pulseWidthFault));

// >>> testbench/pop_process_model.sv
`timescale 1ns/1ps
module pop_process_model (
  // clock
  input wire logic clock,
  // request from the bench
  input wire logic edgeReq,
  // process lines
  input wire logic pulseOut,
  output logic senseInput = 1'b0,
  output logic [7:0] pulseCount = 8'h00
);
  logic [3:0] holdLeft = 4'h0;
  logic lastOut = 1'b0;
  // one clean rising gate edge per request, held a few cycles; no bounce modelled
  always_ff @(posedge clock) begin
    if (edgeReq && !senseInput) begin
      senseInput <= 1'b1;
      holdLeft <= 4'h4;
    end else if (holdLeft != 4'h0) begin
      holdLeft <= holdLeft - 4'h1;
    end else begin
      senseInput <= 1'b0;
    end
  end
  // tally pulses seen on the output line
  always_ff @(posedge clock) begin
    lastOut <= pulseOut;
    if (pulseOut && !lastOut) begin
      pulseCount <= pulseCount + 8'h01;
    end
  end
endmodule // pop_process_model

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench import pop_pkg::*;;
  localparam int FC = 10;
  localparam int SC = 20;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writeData = 32'h0;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic edgeReq = 1'b0;
  logic [31:0] readData;
  logic senseInput;
  logic pulseOut;
  logic sequenceRunning;
  logic goEcho;
  logic pulseWidthFault;
  logic [7:0] pulseCount;
  logic [31:0] seed = 32'h6263; // 25187
  int bad_count = 0;
  int n_compared = 0;
  always #5 clock = ~clock;
  pop_oneshot #(.FAST_CYCLES(FC), .SLOW_CYCLES(SC)) u_pop_oneshot (.clock(clock),
    .reset_n(reset_n), .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData), .senseInput(senseInput), .pulseOut(pulseOut),
    .sequenceRunning(sequenceRunning), .goEcho(goEcho), .pulseWidthFault(pulseWidthFault));
  pop_process_model u_pop_process_model (.clock(clock), .edgeReq(edgeReq), .pulseOut(pulseOut),
    .senseInput(senseInput), .pulseCount(pulseCount));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // short layout delay; truncating divide, sub-0.2 ms fast delays collapse to zero
  function automatic int exp_delay(input int f, input int c, input bit slow);
    int d;
    d = f * c / 10;
    if (d > 65535) d = 65535;
    if (!slow && d < 2) d = 0;
    return d;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // an idle edge after each write keeps strobes from being reassigned in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    @(negedge clock);
    d = readData;
    @(posedge clock);
  endtask
  task automatic gate_edge();
    edgeReq <= 1'b1;
    @(posedge clock);
    edgeReq <= 1'b0;
  endtask
  // waits for one sequence and counts its delay and pulse cycles
  task automatic measure(output int dl, output int pw);
    bit seen;
    seen = 0;
    dl = 0;
    pw = 0;
    for (int n = 0; n < 4000; n++) begin
      @(negedge clock);
      if (sequenceRunning === 1'b1) begin
        seen = 1;
        if (pulseOut === 1'b1) pw++;
        else dl++;
      end else if (seen) break;
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #800000;
    bad_count++;
    test_done();
  end
  initial begin
    logic [31:0] v;
    logic [7:0] p0;
    int f, c, od, d, dur, pe, dl, pw;
    bit slow, lng;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(POP_ADDR_CONFIG, v);
    chk(v, 32'h1);
    wr(POP_ADDR_CTRL, 32'h1);
    repeat (3) @(posedge clock);
    chk(sequenceRunning, 1'b0);
    wr(POP_ADDR_CTRL, 32'h0);
    // random timings over both bases and both layouts
    for (int i = 0; i < 8; i++) begin
      f = (i == 0) ? 0 : int'(rnd() % 21);
      c = int'(rnd() % 41);
      slow = rnd() % 2;
      lng = (i % 3 == 1);
      od = 2 + int'(rnd() % 5);
      d = lng ? od : exp_delay(f, c, slow);
      dur = int'(rnd() % 10);
      if (d == 0 && dur < 2) dur = 2;
      if (i == 1) dur = 0;
      pe = (dur >= (slow ? 1 : 2)) ? dur : 0;
      wr(POP_ADDR_CONFIG, {c[15:0], 8'h00, 1'b0, lng, 1'b0, slow, 4'h0});
      wr(POP_ADDR_DURATION, dur);
      wr(POP_ADDR_ONDELAY, od);
      wr(POP_ADDR_CTRL, {16'h0, f[7:0], 8'h01});
      measure(dl, pw);
      chk(dl, d * (slow ? SC : FC));
      chk(pw, pe * (slow ? SC : FC));
      wr(POP_ADDR_CTRL, 32'h0);
    end
    wr(POP_ADDR_CTRL, 32'h3);
    repeat (3) @(posedge clock);
    chk(sequenceRunning, 1'b0);
    wr(POP_ADDR_CTRL, 32'h0);
    wr(POP_ADDR_CONFIG, 32'h0);
    wr(POP_ADDR_DURATION, 50);
    wr(POP_ADDR_CTRL, 32'h1);
    repeat (100) @(posedge clock);
    wr(POP_ADDR_CTRL, 32'h0);
    @(negedge clock);
    chk({sequenceRunning, pulseOut}, 2'b00);
    wr(POP_ADDR_DURATION, 20);
    wr(POP_ADDR_CTRL, 32'h1);
    fork
      measure(dl, pw);
      begin
        repeat (40) @(posedge clock);
        wr(POP_ADDR_DURATION, 10);
      end
    join
    chk(pw, 10 * FC);
    wr(POP_ADDR_CTRL, 32'h0);
    wr(POP_ADDR_DURATION, 20);
    wr(POP_ADDR_CTRL, 32'h1);
    repeat (80) @(posedge clock);
    wr(POP_ADDR_DURATION, 3);
    @(negedge clock);
    chk({pulseWidthFault, sequenceRunning, pulseOut}, 3'b100);
    wr(POP_ADDR_CTRL, 32'h0);
    wr(POP_ADDR_CTRL, 32'h1);
    fork
      measure(dl, pw);
      begin
        @(negedge clock);
        chk(pulseWidthFault, 1'b0);
      end
    join
    chk(pw, 3 * FC);
    // gate role: go alone must wait for the sensed edge
    wr(POP_ADDR_CTRL, 32'h0);
    wr(POP_ADDR_CONFIG, 32'h20);
    wr(POP_ADDR_CTRL, 32'h1);
    repeat (5) @(posedge clock);
    chk(sequenceRunning, 1'b0);
    p0 = pulseCount;
    rd(POP_ADDR_STATUS, v);
    chk(v[3:0], 4'h8);
    c = int'(v[11:8]);
    fork
      measure(dl, pw);
      begin
        gate_edge();
        repeat (15) @(posedge clock);
        gate_edge();
      end
    join
    chk(pw, 3 * FC);
    chk(dl, 0);
    gate_edge();
    measure(dl, pw);
    chk(pw, 3 * FC);
    chk(pulseCount - p0, 8'h02);
    rd(POP_ADDR_STATUS, v);
    chk(v[11:8], 4'(c + 2));
    wr(POP_ADDR_CTRL, 32'h0);
    wr(POP_ADDR_CONFIG, 32'h80);
    wr(POP_ADDR_CONFIG, 32'h1);
    wr(8'h14, 32'hff);
    rd(POP_ADDR_CONFIG, v);
    chk(v & 32'h7, 32'h0);
    rd(8'h14, v);
    chk(v, 32'h0);
    test_done();
  end
endmodule // testbench
